//--- shared/rcab_pkg.sv
// Constants and carrier types for the receive comma aligner and elastic buffer.
// Assumes a single core clock; link clock and serial bit arrive as plain pins.
package rcab_pkg;

   // -----------------------------------------------------------------
   // Character and buffer geometry
   // -----------------------------------------------------------------
   localparam int CHAR_W      = 10;
   localparam int BUF_DEPTH   = 16;
   localparam int CC_MARGIN   = 2;
   localparam int PEEK_N      = 4;
   localparam int CTR_W       = 4;
   localparam logic [CTR_W-1:0] CTR_LAST = 4'h9;
   localparam logic [CTR_W-1:0] CTR_RST  = 4'h0;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [CHAR_W-1:0] CHAR_RST = 10'h000;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      RCAB_ALIGN_PLUS  = 2'h0,
      RCAB_ALIGN_MINUS = 2'h1,
      RCAB_ALIGN_BOTH  = 2'h2,
      RCAB_ALIGN_USER  = 2'h3
   } rcab_align_mode_t;

   typedef struct packed {
      logic              cc_start;
      logic              cc_end;
      logic [CHAR_W-1:0] chr;
   } rcab_word_t;

   typedef struct packed {
      logic [CHAR_W-1:0] plus_char;
      logic [CHAR_W-1:0] minus_char;
      logic [CHAR_W-1:0] user_char;
   } rcab_targets_t;

   localparam int WORD_W = $bits(rcab_word_t);

endpackage : rcab_pkg

//--- hdl/rcab_elastic_fifo.sv
// Elastic buffer: FIFO whose read pointer can be moved by a signed step.
// Assumes the caller never steps past written data or over unread slots.
`timescale 1ns/1ps
module rcab_elastic_fifo #(
   parameter int WIDTH = rcab_pkg::WORD_W,
   parameter int DEPTH = rcab_pkg::BUF_DEPTH,
   parameter int PEEK  = rcab_pkg::PEEK_N
) (
   input  wire logic                          i_clk,
   input  wire logic                          i_rst_n,
   input  wire logic                          i_wr_valid,
   output logic                               o_wr_ready,
   input  wire logic [WIDTH-1:0]              i_wr_data,
   output logic                               o_rd_valid,
   input  wire logic                          i_rd_ready,
   output logic [WIDTH-1:0]                   o_rd_data,
   output logic [PEEK-1:0][WIDTH-1:0]         o_peek,
   input  wire logic                          i_adj_en,
   input  wire logic signed [$clog2(DEPTH):0] i_adj,
   output logic [$clog2(DEPTH):0]             o_level
);
   localparam int PW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 8 || (1 << PW) != DEPTH || PEEK > DEPTH) begin
         $error("rcab_elastic_fifo: DEPTH must be a power of two, at least 8");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0]      wr_ptr;
   logic [PW:0]      rd_ptr;

   assign o_level    = wr_ptr - rd_ptr;
   assign o_wr_ready = (o_level < (PW+1)'(DEPTH));
   assign o_rd_valid = (o_level != '0);
   assign o_rd_data  = mem[rd_ptr[PW-1:0]];

   always_comb begin
      for (int k = 0; k < PEEK; k++) begin
         o_peek[k] = mem[PW'(rd_ptr[PW-1:0] + PW'(k))];
      end
   end

   // -----------------------------------------------------------------
   // Write side
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_wr_valid && o_wr_ready) begin
         mem[wr_ptr[PW-1:0]] <= i_wr_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr <= '0;
      end else if (i_wr_valid && o_wr_ready) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // Read side; a step replaces the plain increment
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_ptr <= '0;
      end else if (i_adj_en) begin
         rd_ptr <= rd_ptr + $unsigned(i_adj);
      end else if (o_rd_valid && i_rd_ready) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end

endmodule : rcab_elastic_fifo

//--- hdl/rcab_rx_align.sv
// Receive comma aligner, clock correction and elastic read side.
// Assumes link clock and serial bit are asynchronous pins; all else is core clock.
//
// Function
// - With detection on, compare incoming characters against up to two programmed targets.
// - On a target character, pulse comma-detected and align words to it.
// - Target already on the word boundary leaves that boundary unchanged.
// - Target off the boundary moves the boundary and pulses a separate realign output.
// - Every received bit is checked, so alignment is rechecked at each target.
// - With detection off, no alignment to any pattern happens.
// - Target selectable as positive comma, negative comma, either, or user character.
// - Buffer written on the core clock at the pace of the recovered link clock, read by the fabric side.
// - Correction holds the buffer fill around half full.
// - Writing and reading continue whatever the line carries, idles included.
// - Buffer draining: read pointer steps back to reread a repeatable sequence.
// - Repeat hold zero with two-character sequence: repeats may follow each other.
// - Buffer filling: read pointer jumps over a removable sequence, dropping it.
// - One sequence per correction; hold zero also allows skipping two in one step.
// - Sender places correction sequences in gaps; receiver recognises them.
// - Read pointer is also adjustable for channel bonding on a request in a cycle with no pop and no skip.
`timescale 1ns/1ps
module rcab_rx_align #(
   parameter int DEPTH = rcab_pkg::BUF_DEPTH
) (
   input  wire logic                          i_core_clk,
   input  wire logic                          i_reset_n,
   input  wire logic                          i_recovered_rx_clock,
   input  wire logic                          i_rx_bit,
   input  wire logic                          i_comma_en,
   input  wire logic [1:0]                    i_align_mode,
   input  wire rcab_pkg::rcab_targets_t       i_targets,
   input  wire logic [rcab_pkg::CHAR_W-1:0]   i_cc_char0,
   input  wire logic [rcab_pkg::CHAR_W-1:0]   i_cc_char1,
   input  wire logic                          i_cc_len2,
   input  wire logic                          i_correction_repeat_hold,
   input  wire logic                          i_bond_req,
   input  wire logic signed [2:0]             i_bond_delta,
   input  wire logic                          i_rx_ready,
   output logic [rcab_pkg::CHAR_W-1:0]        o_rx_data,
   output logic                               o_rx_valid,
   output logic                               o_comma_det,
   output logic                               o_realign,
   output logic                               o_aligned,
   output logic                               o_cc_repeat,
   output logic                               o_cc_skip,
   output logic                               o_bond_done,
   output logic                               o_buf_overflow,
   output logic                               o_buf_underflow,
   output logic [$clog2(DEPTH):0]             o_buf_level
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = rcab_pkg::CHAR_W;
   localparam logic [PW:0] LOW_MARK  = (PW+1)'(DEPTH/2 - rcab_pkg::CC_MARGIN);
   localparam logic [PW:0] HIGH_MARK = (PW+1)'(DEPTH/2 + rcab_pkg::CC_MARGIN);

   initial begin
      if (DEPTH < 8 || (1 << PW) != DEPTH) begin
         $error("rcab_rx_align: DEPTH must be a power of two, at least 8");
      end
   end

   typedef enum logic [1:0] {
      RD_RUN  = 2'b01,
      RD_HOLD = 2'b10
   } rcab_rd_state_t;

   // -----------------------------------------------------------------
   // Functions
   // -----------------------------------------------------------------
   function automatic logic is_target(input logic [CW-1:0] chr,
                                      input logic [1:0] mode,
                                      input rcab_pkg::rcab_targets_t t);
      logic hit;
      hit = 1'b0;
      case (mode)
         rcab_pkg::RCAB_ALIGN_PLUS:  hit = (chr == t.plus_char);
         rcab_pkg::RCAB_ALIGN_MINUS: hit = (chr == t.minus_char);
         rcab_pkg::RCAB_ALIGN_BOTH:  hit = (chr == t.plus_char) || (chr == t.minus_char);
         rcab_pkg::RCAB_ALIGN_USER:  hit = (chr == t.user_char);
         default:                    hit = 1'b0;
      endcase
      return hit;
   endfunction : is_target

   function automatic logic seq_at(input rcab_pkg::rcab_word_t first,
                                   input rcab_pkg::rcab_word_t last);
      return first.cc_start && last.cc_end;
   endfunction : seq_at

   // -----------------------------------------------------------------
   // Reset release
   // -----------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // -----------------------------------------------------------------
   // Pin synchronisers and link clock edge
   // -----------------------------------------------------------------
   // Both pins take the same depth so the bit keeps its place against the edge
   logic lclk_meta;
   logic lclk_sync;
   logic lclk_prev;
   logic bit_meta;
   logic bit_sync;
   logic link_tick;

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lclk_meta <= 1'b0;
         lclk_sync <= 1'b0;
         lclk_prev <= 1'b0;
         bit_meta  <= 1'b0;
         bit_sync  <= 1'b0;
      end else begin
         lclk_meta <= i_recovered_rx_clock;
         lclk_sync <= lclk_meta;
         lclk_prev <= lclk_sync;
         bit_meta  <= i_rx_bit;
         bit_sync  <= bit_meta;
      end
   end

   assign link_tick = lclk_sync && !lclk_prev;

   // -----------------------------------------------------------------
   // Deserialiser and word alignment
   // -----------------------------------------------------------------
   logic [CW-1:0]             shift;
   logic [CW-1:0]             next_shift;
   logic [rcab_pkg::CTR_W-1:0] bit_ctr;
   logic                      hit;
   logic                      word_stb;
   logic [CW-1:0]             word_chr;

   assign next_shift = {bit_sync, shift[CW-1:1]};
   assign hit        = i_comma_en && is_target(next_shift, i_align_mode, i_targets);

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift <= rcab_pkg::CHAR_RST;
      end else if (link_tick) begin
         shift <= next_shift;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_ctr     <= rcab_pkg::CTR_RST;
         word_stb    <= 1'b0;
         word_chr    <= rcab_pkg::CHAR_RST;
         o_comma_det <= 1'b0;
         o_realign   <= 1'b0;
      end else begin
         word_stb    <= 1'b0;
         o_comma_det <= 1'b0;
         o_realign   <= 1'b0;
         if (link_tick) begin
            // Each new bit closes a candidate character, so every target is seen
            o_comma_det <= hit;
            if (bit_ctr == rcab_pkg::CTR_LAST) begin
               word_stb <= 1'b1;
               word_chr <= next_shift;
               bit_ctr  <= rcab_pkg::CTR_RST;
            end else if (hit) begin
               word_stb  <= 1'b1;
               word_chr  <= next_shift;
               bit_ctr   <= rcab_pkg::CTR_RST;
               o_realign <= 1'b1;
            end else begin
               bit_ctr <= bit_ctr + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_aligned <= 1'b0;
      end else if (!i_comma_en) begin
         o_aligned <= 1'b0;
      end else if (link_tick && hit) begin
         o_aligned <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // Correction sequence marking on the write side
   // -----------------------------------------------------------------
   logic                 prev_char0;
   logic                 m0;
   logic                 m1;
   rcab_pkg::rcab_word_t wr_word;

   assign m0 = (word_chr == i_cc_char0);
   assign m1 = (word_chr == i_cc_char1);

   always_comb begin
      wr_word.chr      = word_chr;
      wr_word.cc_start = m0;
      wr_word.cc_end   = i_cc_len2 ? (prev_char0 && m1) : m0;
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_char0 <= 1'b0;
      end else if (word_stb) begin
         prev_char0 <= m0;
      end
   end

   // -----------------------------------------------------------------
   // Elastic buffer
   // -----------------------------------------------------------------
   logic                                    fifo_wr_ready;
   logic                                    fifo_valid;
   logic                                    fifo_pop;
   logic [rcab_pkg::WORD_W-1:0]             fifo_data;
   logic [rcab_pkg::PEEK_N-1:0][rcab_pkg::WORD_W-1:0] peek;
   logic                                    adj_en;
   logic signed [PW:0]                      adj;
   logic [PW:0]                             level;

   // Written every character, idle or payload alike
   rcab_elastic_fifo #(
      .WIDTH (rcab_pkg::WORD_W),
      .DEPTH (DEPTH),
      .PEEK  (rcab_pkg::PEEK_N)
   ) u_fifo (
      .i_clk      (i_core_clk),
      .i_rst_n    (rst_n),
      .i_wr_valid (word_stb),
      .o_wr_ready (fifo_wr_ready),
      .i_wr_data  (wr_word),
      .o_rd_valid (fifo_valid),
      .i_rd_ready (fifo_pop),
      .o_rd_data  (fifo_data),
      .o_peek     (peek),
      .i_adj_en   (adj_en),
      .i_adj      (adj),
      .o_level    (level)
   );

   // -----------------------------------------------------------------
   // Clock correction and bonding decision
   // -----------------------------------------------------------------
   rcab_rd_state_t       rd_state;
   rcab_pkg::rcab_word_t head;
   rcab_pkg::rcab_word_t pk [rcab_pkg::PEEK_N];
   logic                 out_free;
   logic                 pop_ok;
   logic                 do_skip;
   logic                 do_skip2;
   logic                 do_repeat;
   logic                 do_bond;
   logic [PW:0]          seq_len;

   always_comb begin
      for (int k = 0; k < rcab_pkg::PEEK_N; k++) begin
         pk[k] = peek[k];
      end
   end

   assign head     = fifo_data;
   assign seq_len  = i_cc_len2 ? (PW+1)'(2) : (PW+1)'(1);
   assign out_free = !o_rx_valid || i_rx_ready;
   assign pop_ok   = out_free && fifo_valid;

   // Thresholds sit either side of half full; a skip needs the whole sequence present
   always_comb begin
      do_skip  = 1'b0;
      do_skip2 = 1'b0;
      if (rd_state == RD_RUN && level > HIGH_MARK) begin
         if (i_cc_len2) begin
            do_skip  = seq_at(pk[0], pk[1]);
            do_skip2 = do_skip && !i_correction_repeat_hold && seq_at(pk[2], pk[3]);
         end else begin
            do_skip  = seq_at(pk[0], pk[0]);
            do_skip2 = do_skip && !i_correction_repeat_hold && seq_at(pk[1], pk[1]);
         end
      end
   end

   // Repeat only while well below half full, so rewound slots are never overwritten
   assign do_repeat = pop_ok && !do_skip && head.cc_end && level < LOW_MARK
                      && rd_state == RD_RUN;
   assign do_bond   = i_bond_req && !do_skip && !pop_ok;
   assign fifo_pop  = pop_ok && !do_skip;

   always_comb begin
      adj_en = 1'b0;
      adj    = '0;
      if (do_skip) begin
         adj_en = 1'b1;
         adj    = do_skip2 ? $signed(seq_len << 1) : $signed(seq_len);
      end else if (do_repeat) begin
         adj_en = 1'b1;
         adj    = $signed((PW+1)'(1) - seq_len);
      end else if (do_bond) begin
         adj_en = 1'b1;
         adj    = (PW+1)'(i_bond_delta);
      end
   end

   // Hold set: one correction, then wait for a word outside any sequence
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_state <= RD_RUN;
      end else begin
         case (rd_state)
            RD_RUN: begin
               if ((do_skip || do_repeat) && i_correction_repeat_hold) begin
                  rd_state <= RD_HOLD;
               end
            end
            RD_HOLD: begin
               if (fifo_pop && !head.cc_start && !head.cc_end) begin
                  rd_state <= RD_RUN;
               end
            end
            default: rd_state <= RD_RUN;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Output stage
   // -----------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_rx_data  <= rcab_pkg::CHAR_RST;
         o_rx_valid <= 1'b0;
      end else if (out_free) begin
         o_rx_valid <= fifo_pop;
         if (fifo_pop) begin
            o_rx_data <= head.chr;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_cc_repeat     <= 1'b0;
         o_cc_skip       <= 1'b0;
         o_bond_done     <= 1'b0;
         o_buf_overflow  <= 1'b0;
         o_buf_underflow <= 1'b0;
         o_buf_level     <= '0;
      end else begin
         o_cc_repeat     <= do_repeat;
         o_cc_skip       <= do_skip;
         o_bond_done     <= do_bond;
         o_buf_overflow  <= word_stb && !fifo_wr_ready;
         o_buf_underflow <= out_free && !fifo_valid;
         o_buf_level     <= level;
      end
   end

endmodule : rcab_rx_align

//--- verification/rcab_rx_align_properties.sv
// Checker: port-level timing relations of the comma aligner and buffer.
// Assumes the core clock domain only; bound to the top module below.
`timescale 1ns/1ps
module rcab_rx_align_properties #(
   parameter int DEPTH = rcab_pkg::BUF_DEPTH
) (
   input wire logic                        i_core_clk,
   input wire logic                        i_reset_n,
   input wire logic                        i_comma_en,
   input wire logic                        i_bond_req,
   input wire logic                        i_rx_ready,
   input wire logic [rcab_pkg::CHAR_W-1:0] o_rx_data,
   input wire logic                        o_rx_valid,
   input wire logic                        o_comma_det,
   input wire logic                        o_realign,
   input wire logic                        o_aligned,
   input wire logic                        o_cc_repeat,
   input wire logic                        o_cc_skip,
   input wire logic                        o_bond_done,
   input wire logic                        o_buf_overflow,
   input wire logic [$clog2(DEPTH):0]      o_buf_level
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   a_det_single: assert property (o_comma_det |=> !o_comma_det)
      else $error("comma_det longer than one cycle");
   a_realign_det: assert property (o_realign |-> o_comma_det)
      else $error("realign without comma_det");
   a_off_quiet: assert property (!$past(i_comma_en) && !$past(i_comma_en, 2)
      |-> !o_realign && !o_aligned) else $error("alignment while detection off");
   a_aligned_rise: assert property ($rose(o_aligned) |-> o_comma_det)
      else $error("aligned set without a target");
   a_cc_exclusive: assert property (!(o_cc_repeat && o_cc_skip))
      else $error("repeat and skip together");
   a_skip_full: assert property (o_cc_skip |-> $past(o_buf_level) > DEPTH / 2)
      else $error("skip below half full");
   a_repeat_low: assert property (o_cc_repeat |-> $past(o_buf_level) < DEPTH / 2)
      else $error("repeat above half full");
   a_valid_hold: assert property (o_rx_valid && !i_rx_ready
      |=> o_rx_valid && $stable(o_rx_data)) else $error("output word not held");
   a_bond_cause: assert property (o_bond_done |-> $past(i_bond_req))
      else $error("bond done without request");
   a_ovf_full: assert property (o_buf_overflow |-> $past(o_buf_level) >= DEPTH - 2)
      else $error("overflow below full");
endmodule : rcab_rx_align_properties

bind rcab_rx_align rcab_rx_align_properties #(.DEPTH(DEPTH)) rcab_rx_align_properties_inst (
   .i_core_clk, .i_reset_n, .i_comma_en, .i_bond_req, .i_rx_ready, .o_rx_data, .o_rx_valid,
   .o_comma_det, .o_realign, .o_aligned, .o_cc_repeat, .o_cc_skip, .o_bond_done,
   .o_buf_overflow, .o_buf_level);

//--- verification/rcab_link_model.sv
// Remote serial sender: characters out bit by bit with their own clock.
// Assumes the bench calls its tasks; the clock stands still between calls.
`timescale 1ns/1ps
module rcab_link_model #(
   parameter int HALF_NS = 80
) (
   output logic o_link_clk,
   output logic o_link_bit
);
   initial begin
      o_link_clk = 1'b0;
      o_link_bit = 1'b0;
   end

   // First bit first, data changes half a period before the rising edge
   task automatic send_bits(input logic [rcab_pkg::CHAR_W-1:0] c, input int n);
      for (int i = 0; i < n; i++) begin
         o_link_bit = c[i];
         #(HALF_NS) o_link_clk = 1'b1;
         #(HALF_NS) o_link_clk = 1'b0;
      end
   endtask : send_bits

   // Released line shows no stale value
   task automatic release_line();
      o_link_bit = ~o_link_bit;
   endtask : release_line
endmodule : rcab_link_model

//--- verification/test_rcab_rx_align.sv
// Testbench: random frames through the link model, stream and buffer checks.
// Assumes the link model owns the link pins; all other inputs are driven here.
`timescale 1ns/1ps
module test_rcab_rx_align;
   // ---------------------------------------------------------------
   // Stimulus and observation
   // ---------------------------------------------------------------
   localparam int W = rcab_pkg::CHAR_W;
   localparam logic [W-1:0] TGT [4] = '{10'h0fa, 10'h305, 10'h0fa, 10'h0f8};
   localparam rcab_pkg::rcab_targets_t TG = '{10'h0fa, 10'h305, 10'h0f8};
   logic             clk = 1'b0, rst_n = 1'b0, en = 1'b0, len2 = 1'b0, hold = 1'b0;
   logic             bond = 1'b0, rdy = 1'b1, lclk, lbit;
   logic signed [2:0] bdelta = 3'sh0;
   logic [1:0]       mode = 2'h0;
   logic [W-1:0]     data;
   logic             valid, det, realign, aligned, rep, skip, bdone, ovf, unf;
   logic [4:0]       level;
   logic [W-1:0]     rxq[$], ef[$], got[$];
   int               err_total = 0, tests_run = 0, off = -1;
   int               det_n, re_n, rep_n = 0, skip_n = 0, ovf_n = 0, unf_n = 0, bd_n = 0;
   bit               rnd_rdy = 0;

   always #4 clk = ~clk;

   rcab_rx_align #(.DEPTH(16)) rcab_rx_align_inst (
      .i_core_clk(clk), .i_reset_n(rst_n), .i_recovered_rx_clock(lclk), .i_rx_bit(lbit),
      .i_comma_en(en), .i_align_mode(mode), .i_targets(TG), .i_cc_char0(10'h0cc),
      .i_cc_char1(10'h133), .i_cc_len2(len2), .i_correction_repeat_hold(hold),
      .i_bond_req(bond), .i_bond_delta(bdelta), .i_rx_ready(rdy), .o_rx_data(data),
      .o_rx_valid(valid), .o_comma_det(det), .o_realign(realign), .o_aligned(aligned),
      .o_cc_repeat(rep), .o_cc_skip(skip), .o_bond_done(bdone), .o_buf_overflow(ovf),
      .o_buf_underflow(unf), .o_buf_level(level));

   rcab_link_model rcab_link_model_inst (.o_link_clk(lclk), .o_link_bit(lbit));

   always @(posedge clk) begin
      det_n += int'(det === 1'b1);
      re_n += int'(realign === 1'b1);
      rep_n += int'(rep === 1'b1);
      skip_n += int'(skip === 1'b1);
      ovf_n += int'(ovf === 1'b1);
      unf_n += int'(unf === 1'b1);
      bd_n += int'(bdone === 1'b1);
      if (valid === 1'b1 && rdy === 1'b1) rxq.push_back(data);
      if (rnd_rdy) rdy <= #1 1'($urandom);
   end

   task automatic chk(input string name, input logic [W-1:0] seen, input logic [W-1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report

   // s filler bits, then a decoy comma except in mode 2, then the target, then n words
   task automatic frame(input logic e, input int m, input int s, input int n);
      logic [W-1:0] t, w;
      logic [W-1:0] q[$];
      int k;
      @(posedge clk);
      #1;
      en = e;
      mode = 2'(m);
      len2 = 1'($urandom);
      hold = 1'($urandom);
      det_n = 0;
      re_n = 0;
      rxq.delete();
      ef.delete();
      got.delete();
      t = (m == 2) ? TGT[$urandom % 2] : TGT[m];
      q.push_back(t);
      ef.push_back(t);
      for (int i = 0; i < n; i++) begin
         w = ($urandom % 3 == 0) ? 10'h0cc : (($urandom % 2) ? 10'h155 : 10'h2aa);
         q.push_back(w);
         if (w == 10'h0cc && len2) q.push_back(10'h133); // Whole sequence in a gap
         if (w != 10'h0cc) ef.push_back(w);
      end
      rcab_link_model_inst.send_bits(10'h155, s);
      if (m != 2) rcab_link_model_inst.send_bits(TGT[(m == 1) ? 0 : 1], 10);
      foreach (q[i]) rcab_link_model_inst.send_bits(q[i], 10);
      // Idle tail lifts the fill past the repeat mark, so no payload stays parked
      repeat (4) begin
         rcab_link_model_inst.send_bits(10'h0cc, 10);
         if (len2) rcab_link_model_inst.send_bits(10'h133, 10);
      end
      rcab_link_model_inst.release_line();
      repeat (300) @(posedge clk);
      #1;
      chk("comma_det count", 10'(det_n), 10'(e));
      chk("aligned", 10'(aligned), 10'(e));
      if (e) begin
         if (off >= 0) chk("realign count", 10'(re_n), 10'((off + s) % 10 != 0));
         off = 0;
         foreach (rxq[i]) if (rxq[i] != 10'h0cc && !(len2 && rxq[i] == 10'h133))
            got.push_back(rxq[i]);
         k = got.size() - ef.size();
         if (k < 0) k = 0;
         foreach (ef[i]) chk("rx_data", got[k + i], ef[i]);
      end else begin
         chk("realign while off", 10'(re_n), 10'h000);
         if (off >= 0) off = (off + s) % 10;
      end
      $display("frame mode %0d shift %0d words %0d done", m, s, n);
   endtask : frame

   // Fill with correction words then payload until refused, bond, then drain
   task automatic fill_test();
      @(posedge clk);
      #1;
      rnd_rdy = 0;
      @(posedge clk);
      #1;
      rdy = 1'b0;
      hold = 1'b0;
      len2 = 1'b0;
      mode = 2'h0;
      skip_n = 0;
      rcab_link_model_inst.send_bits(10'h0fa, 10);
      repeat (14) rcab_link_model_inst.send_bits(10'h0cc, 10);
      repeat (20) rcab_link_model_inst.send_bits(10'h155, 10);
      rcab_link_model_inst.release_line();
      repeat (20) @(posedge clk);
      #1;
      chk("skip seen", 10'(skip_n > 0), 10'h001);
      chk("overflow seen", 10'(ovf_n > 0), 10'h001);
      bond = 1'b1;
      bdelta = 3'sh1;
      @(posedge clk);
      #1;
      bond = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("bond done", 10'(bd_n), 10'h001);
      chk("bond step", 10'(level < 5'h10), 10'h001);
      unf_n = 0;
      // One repeat per idle run, so the drain cannot park on a sequence
      hold = 1'b1;
      rdy = 1'b1;
      repeat (100) @(posedge clk);
      #1;
      chk("underflow seen", 10'(unf_n > 0), 10'h001);
      chk("level drained", 10'(level), 10'h000);
      $display("fill and drain done");
   endtask : fill_test

   initial begin
      #700000;
      err_total++;
      final_report();
   end

   initial begin
      void'($urandom(58105));
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      rnd_rdy = 1;
      frame(1'b1, 0, 3, 6);
      frame(1'b1, 1, 0, 8);
      frame(1'b1, 3, 9, 8);
      frame(1'b0, 2, 5, 4);
      frame(1'b1, 2, 2, 6);
      for (int i = 0; i < 4; i++) frame(1'b1, $urandom % 4, $urandom % 10, 4 + $urandom % 12);
      chk("repeats seen", 10'(rep_n > 0), 10'h001);
      fill_test();
      final_report();
   end
endmodule : test_rcab_rx_align
